// ---- core/kpi_top.sv ----
// Key pin interrupt block with its AHB-Lite register slave.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ns
module kpi_top #(
  parameter int ADDR_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [kpi_pkg::KEY_W-1:0] key_input_pins,
  input wire logic stop_mode,
  output logic irq,
  output logic wake_req
);

  // ==========================================================================
  // State
  kpi_pkg::kpi_state_t st_reg;
  kpi_pkg::kpi_state_t st_next;

  logic [kpi_pkg::KEY_W-1:0] asserted_now;
  logic [kpi_pkg::KEY_W-1:0] asserted_prev;
  logic [kpi_pkg::KEY_W-1:0] edge_hit;
  logic [kpi_pkg::KEY_W-1:0] raw_asserted;
  logic any_asserted;
  logic detect;
  logic addr_valid;
  logic [kpi_pkg::IDX_W-1:0] idx;
  kpi_pkg::kpi_sel_t sel;
  logic ack_write;
  logic [7:0] wbyte;
  logic [7:0] sc_read;

  // ==========================================================================
  // Detection
  always_comb begin
    asserted_now = st_reg.pin_enable_bits &
      ~(st_reg.sync2 ^ st_reg.pin_polarity_select);
    asserted_prev = st_reg.pin_enable_bits &
      ~(st_reg.prev ^ st_reg.pin_polarity_select);
    edge_hit = asserted_now & ~asserted_prev;
    any_asserted = |asserted_now;
    detect = (st_reg.armed && (|edge_hit)) ||
      (st_reg.level_detect_mode && any_asserted);
  end

  // unclocked stop-mode wake path
  // Apart from sync1, the raw pins feed only this wake term, since the bus clock may be
  // stopped; it is never used to change any register.
  assign raw_asserted = st_reg.pin_enable_bits &
    ~(key_input_pins ^ st_reg.pin_polarity_select);

  // ==========================================================================
  // Address decode
  always_comb begin
    idx = haddr[ADDR_W-1:2];
    addr_valid = hsel && hready &&
      (htrans == kpi_pkg::HTRANS_NONSEQ || htrans == kpi_pkg::HTRANS_SEQ);
    if (!addr_valid) begin
      sel = kpi_pkg::KPI_SEL_NONE;
    end else if (idx == kpi_pkg::IDX_STATUS_CONTROL) begin
      sel = kpi_pkg::KPI_SEL_SC;
    end else if (idx == kpi_pkg::IDX_PIN_ENABLE) begin
      sel = kpi_pkg::KPI_SEL_PE;
    end else if (idx == kpi_pkg::IDX_POLARITY_SELECT) begin
      sel = kpi_pkg::KPI_SEL_ES;
    end else if (idx == kpi_pkg::IDX_EVENT_STATUS) begin
      sel = kpi_pkg::KPI_SEL_EVS;
    end else if (idx == kpi_pkg::IDX_EVENT_MASK) begin
      sel = kpi_pkg::KPI_SEL_EVM;
    end else begin
      sel = kpi_pkg::KPI_SEL_NONE;
    end
  end

  // ==========================================================================
  // Next state
  always_comb begin
    st_next = st_reg;
    wbyte = hwdata[7:0];
    ack_write = 1'b0;
    sc_read = 8'h00;

    // Two flops on every pin before the detection logic looks at it.
    st_next.sync1 = key_input_pins;
    st_next.sync2 = st_reg.sync1;
    st_next.prev = st_reg.sync2;

    if (detect) begin
      st_next.armed = 1'b0;
    end else if (!any_asserted) begin
      st_next.armed = 1'b1;
    end

    // Register writes land in the data phase.
    if (st_reg.dp_write) begin
      unique case (st_reg.dp_sel)
        kpi_pkg::KPI_SEL_SC: begin
          st_next.level_detect_mode = wbyte[kpi_pkg::SC_MODE_BIT];
          st_next.key_irq_enable = wbyte[kpi_pkg::SC_IRQ_ENABLE_BIT];
          ack_write = wbyte[kpi_pkg::SC_ACK_BIT];
        end
        kpi_pkg::KPI_SEL_PE: st_next.pin_enable_bits = wbyte;
        kpi_pkg::KPI_SEL_ES: st_next.pin_polarity_select = wbyte;
        kpi_pkg::KPI_SEL_EVS: begin
          st_next.ev_status = st_reg.ev_status & ~wbyte[kpi_pkg::EV_W-1:0];
        end
        kpi_pkg::KPI_SEL_EVM: st_next.ev_mask = wbyte[kpi_pkg::EV_W-1:0];
        kpi_pkg::KPI_SEL_NONE: ;
      endcase
    end

    if (ack_write && !any_asserted) begin
      st_next.key_event_flag = 1'b0;
    end
    // detection sets the flag
    // A detection in the same cycle as the acknowledge wins.
    if (detect) begin
      st_next.key_event_flag = 1'b1;
    end

    // Sticky events; a set in the clearing cycle also wins.
    if (detect) begin
      st_next.ev_status[kpi_pkg::EV_KEY_BIT] = 1'b1;
    end
    if (ack_write && any_asserted) begin
      st_next.ev_status[kpi_pkg::EV_REFUSED_BIT] = 1'b1;
    end

    // Address phase capture.
    st_next.dp_write = hwrite && (sel != kpi_pkg::KPI_SEL_NONE);
    st_next.dp_sel = sel;

    // Read data is taken from the next state so a write just before a
    // read of the same register is already visible.
    // upper and ack read zero
    sc_read[kpi_pkg::SC_FLAG_BIT] = st_next.key_event_flag;
    sc_read[kpi_pkg::SC_IRQ_ENABLE_BIT] = st_next.key_irq_enable;
    sc_read[kpi_pkg::SC_MODE_BIT] = st_next.level_detect_mode;
    st_next.hrdata = kpi_pkg::RST_RDATA;
    if (!hwrite) begin
      unique case (sel)
        kpi_pkg::KPI_SEL_SC: st_next.hrdata = {24'h000000, sc_read};
        kpi_pkg::KPI_SEL_PE: begin
          st_next.hrdata = {24'h000000, st_next.pin_enable_bits};
        end
        kpi_pkg::KPI_SEL_ES: begin
          st_next.hrdata = {24'h000000, st_next.pin_polarity_select};
        end
        kpi_pkg::KPI_SEL_EVS: begin
          st_next.hrdata = {30'h00000000, st_next.ev_status};
        end
        kpi_pkg::KPI_SEL_EVM: begin
          st_next.hrdata = {30'h00000000, st_next.ev_mask};
        end
        kpi_pkg::KPI_SEL_NONE: ;
      endcase
    end
  end

  // ==========================================================================
  // Registers
  // everything resets to zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg.sync1 <= kpi_pkg::RST_KEY_REG;
      st_reg.sync2 <= kpi_pkg::RST_KEY_REG;
      st_reg.prev <= kpi_pkg::RST_KEY_REG;
      st_reg.pin_enable_bits <= kpi_pkg::RST_KEY_REG;
      st_reg.pin_polarity_select <= kpi_pkg::RST_KEY_REG;
      st_reg.level_detect_mode <= 1'b0;
      st_reg.key_irq_enable <= 1'b0;
      st_reg.key_event_flag <= 1'b0;
      st_reg.armed <= 1'b0;
      st_reg.ev_status <= kpi_pkg::RST_EV_REG;
      st_reg.ev_mask <= kpi_pkg::RST_EV_REG;
      st_reg.dp_write <= 1'b0;
      st_reg.dp_sel <= kpi_pkg::KPI_SEL_NONE;
      st_reg.hrdata <= kpi_pkg::RST_RDATA;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs
  // Zero wait states; every access, mapped or not, ends OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st_reg.hrdata;

  assign irq = (st_reg.key_event_flag && st_reg.key_irq_enable) ||
    (|(st_reg.ev_status & st_reg.ev_mask));

  assign wake_req = irq ||
    (stop_mode && st_reg.key_irq_enable && (|raw_asserted));

endmodule : kpi_top

// ---- core/kpi_pkg.sv ----
// Package of constants and types for the key pin interrupt block.
package kpi_pkg;

  // ==========================================================================
  // Widths
  localparam int KEY_W = 8;
  localparam int IDX_W = 14;

  // ==========================================================================
  // Register indexes; the byte address is four times the index.
  localparam logic [IDX_W-1:0] IDX_STATUS_CONTROL = 14'h003C;
  localparam logic [IDX_W-1:0] IDX_PIN_ENABLE = 14'h307C;
  localparam logic [IDX_W-1:0] IDX_POLARITY_SELECT = 14'h307D;
  localparam logic [IDX_W-1:0] IDX_EVENT_STATUS = 14'h3080;
  localparam logic [IDX_W-1:0] IDX_EVENT_MASK = 14'h3081;

  // ==========================================================================
  // Status and control field positions.
  localparam int SC_MODE_BIT = 0;
  localparam int SC_IRQ_ENABLE_BIT = 1;
  localparam int SC_ACK_BIT = 2;
  localparam int SC_FLAG_BIT = 3;

  // Event status and mask field positions.
  localparam int EV_KEY_BIT = 0;
  localparam int EV_REFUSED_BIT = 1;
  localparam int EV_W = 2;

  // ==========================================================================
  // Reset values.
  localparam logic [KEY_W-1:0] RST_KEY_REG = 8'h00;
  localparam logic [EV_W-1:0] RST_EV_REG = 2'h0;
  localparam logic [31:0] RST_RDATA = 32'h0000_0000;

  // ==========================================================================
  // AHB-Lite encodings.
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;

  typedef enum logic [2:0] {
    KPI_SEL_NONE,
    KPI_SEL_SC,
    KPI_SEL_PE,
    KPI_SEL_ES,
    KPI_SEL_EVS,
    KPI_SEL_EVM
  } kpi_sel_t;

  typedef struct packed {
    logic [KEY_W-1:0] sync1;
    logic [KEY_W-1:0] sync2;
    logic [KEY_W-1:0] prev;
    logic [KEY_W-1:0] pin_enable_bits;
    logic [KEY_W-1:0] pin_polarity_select;
    logic level_detect_mode;
    logic key_irq_enable;
    logic key_event_flag;
    logic armed;
    logic [EV_W-1:0] ev_status;
    logic [EV_W-1:0] ev_mask;
    logic dp_write;
    kpi_sel_t dp_sel;
    logic [31:0] hrdata;
  } kpi_state_t;

endpackage : kpi_pkg

// ---- dv/kpi_props.sv ----
// Port checker of the key pin interrupt block.
`timescale 1ns/1ns
module kpi_props #(
  parameter int ADDR_W = 16
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic stop_mode,
  input wire logic irq,
  input wire logic wake_req
);
  // ==========================================================================
  // Assertions
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_sc_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) rd_sc_reg <= 1'b0;
    else rd_sc_reg <= hsel && htrans[1] && !hwrite && haddr == 16'h00F0;
  end
  chk_ready_high: assert property (hreadyout) else $error("wait state");
  chk_resp_okay: assert property (!hresp) else $error("error response");
  chk_sc_reserved: assert property (
    rd_sc_reg |-> hrdata[7:4] == 4'h0) else $error("reserved bits set");
  chk_ack_reads_zero: assert property (
    rd_sc_reg |-> !hrdata[2]) else $error("ack bit read as one");
  chk_upper_zero: assert property (
    hrdata[31:8] == 24'h0) else $error("upper read bits set");
  chk_reset_quiet: assert property (
    $rose(hresetn) |-> !irq && hrdata == 32'h0) else $error("busy reset");
  chk_wake_irq: assert property (
    irq |-> wake_req) else $error("irq without wake");
  chk_wake_run: assert property (
    !stop_mode |-> wake_req == irq) else $error("wake outside stop");
  chk_irq_fall: assert property (
    $fell(irq) |-> $past(hsel && htrans[1] && hwrite, 2))
    else $error("irq fell without write");
endmodule : kpi_props
bind kpi_top kpi_props #(.ADDR_W(ADDR_W)) u_kpi_props (.hclk(hclk),
  .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .stop_mode(stop_mode), .irq(irq), .wake_req(wake_req));

// ---- dv/kpi_key_model.sv ----
// Key switch model driving the key pins, promptly or a cycle late.
`timescale 1ns/1ns
module kpi_key_model (
  input wire logic hclk,
  input wire logic [7:0] level_cmd,
  input wire logic slow,
  output logic [7:0] key_input_pins
);
  logic [7:0] lag_reg = 8'hFF;
  initial key_input_pins = 8'hFF;
  // A slow contact settles late, so detection must not assume a fixed lag.
  always @(posedge hclk) begin
    lag_reg <= level_cmd;
    key_input_pins <= slow ? lag_reg : level_cmd;
  end
endmodule : kpi_key_model

// ---- dv/tb_top.sv ----
// Self-checking bench of the key pin interrupt block.
`timescale 1ns/1ns
module tb_top;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [15:0] haddr = 16'h0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic stop_mode = 1'b0;
  logic slow = 1'b0;
  logic [7:0] cmd = 8'hFF;
  logic hready, hresp, irq, wake_req, ie, md;
  logic [31:0] hrdata, rd;
  logic [7:0] pins, pe, es;
  int err_total = 0, num_checks = 0, cyc = 0, seed = 12041;
  localparam logic [15:0] A_SC = {kpi_pkg::IDX_STATUS_CONTROL, 2'h0};
  localparam logic [15:0] A_PE = {kpi_pkg::IDX_PIN_ENABLE, 2'h0};
  localparam logic [15:0] A_ES = {kpi_pkg::IDX_POLARITY_SELECT, 2'h0};
  localparam logic [15:0] A_EVS = {kpi_pkg::IDX_EVENT_STATUS, 2'h0};
  localparam logic [15:0] A_EVM = {kpi_pkg::IDX_EVENT_MASK, 2'h0};
  logic [15:0] regs [4] = '{A_SC, A_PE, A_ES, 16'h0100};

  kpi_top #(.ADDR_W(16)) u_kpi_top (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .key_input_pins(pins),
    .stop_mode(stop_mode), .irq(irq), .wake_req(wake_req));
  kpi_key_model u_kpi_key_model (.hclk(hclk), .level_cmd(cmd), .slow(slow),
    .key_input_pins(pins));

  // ==========================================================================
  // Tasks and expectations
  initial forever #5 hclk = ~hclk;
  function automatic logic [31:0] sc_exp(input logic m, i, f);
    return {28'h0, f, 1'b0, i, m};
  endfunction : sc_exp
  task automatic chk(input string n, input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic [15:0] a, input logic w, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= kpi_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic summarize();
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      summarize();
    end
  end

  // ==========================================================================
  // Scenarios
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      bus(regs[k], 1'b0, 32'h0);
      chk("reset value", rd, 32'h0);
    end
    // Each pass enables one pin with random polarity, mode and enable.
    for (int i = 0; i < 24; i++) begin
      pe = 8'h01 << (i % 8);
      es = $random(seed);
      md = $random(seed);
      ie = $random(seed);
      stop_mode <= $random(seed);
      slow <= $random(seed);
      cmd <= ~es;
      bus(A_ES, 1'b1, {24'h0, es});
      bus(A_PE, 1'b1, {24'h0, pe});
      bus(A_SC, 1'b1, {28'h0, 2'h3, ie, md});
      bus(A_SC, 1'b0, 32'h0);
      chk("sc idle", rd, sc_exp(md, ie, 1'b0));
      cmd <= es ^ pe;
      repeat (8) @(posedge hclk);
      bus(A_SC, 1'b0, 32'h0);
      chk("disabled pin", rd, sc_exp(md, ie, 1'b0));
      chk("disabled wake", wake_req, 32'h0);
      cmd <= es;
      // The raw pin reaches the stop wake before the synchronised flag.
      repeat (3) @(posedge hclk);
      chk("stop wake", wake_req, {31'h0, stop_mode & ie});
      chk("irq early", irq, 32'h0);
      repeat (5) @(posedge hclk);
      chk("irq", irq, {31'h0, ie});
      chk("wake", wake_req, {31'h0, ie});
      bus(A_SC, 1'b1, {28'h0, 2'h1, ie, md});
      bus(A_SC, 1'b0, 32'h0);
      chk("held ack", rd, sc_exp(md, ie, 1'b1));
      bus(A_PE, 1'b1, 32'h0);
      bus(A_SC, 1'b1, {28'h0, 2'h1, ie, md});
      bus(A_SC, 1'b0, 32'h0);
      chk("ack disabled", rd, sc_exp(md, ie, 1'b0));
      // Enabling a pin that already sits asserted: only a level counts.
      bus(A_PE, 1'b1, {24'h0, pe});
      bus(A_SC, 1'b0, 32'h0);
      chk("late enable", rd, sc_exp(md, ie, md));
      cmd <= ~es;
      repeat (8) @(posedge hclk);
      bus(A_SC, 1'b1, {28'h0, 2'h1, ie, md});
      bus(A_SC, 1'b0, 32'h0);
      chk("cleared", rd, sc_exp(md, ie, 1'b0));
    end
    bus(A_EVM, 1'b1, 32'h3);
    bus(A_SC, 1'b1, 32'h0);
    bus(A_EVM, 1'b0, 32'h0);
    chk("event mask", rd, 32'h3);
    chk("event irq", irq, 32'h1);
    bus(A_EVS, 1'b1, 32'h3);
    bus(A_EVS, 1'b0, 32'h0);
    chk("event clear", rd, 32'h0);
    chk("irq clear", irq, 32'h0);
    summarize();
  end
endmodule : tb_top
